// *** include/adc_cfg_defines.svh ***
// Register offsets, field positions, reset values and codes of the converter control block
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CONTROL_CHANNEL_RUN   8'h00
`define OFF_REFERENCE_PORT_CONFIG 8'h04
`define OFF_CLOCK_ACQ_CONFIG      8'h08
`define OFF_RESULT_HIGH_BYTE      8'h0c
`define OFF_RESULT_LOW_BYTE       8'h10
`define OFF_IRQ_STATUS            8'h14
`define OFF_IRQ_MASK              8'h18

// ****************************************
// Field positions
// ****************************************
`define CTL_ENABLE_BIT   0
`define CTL_RUN_BIT      1
`define CTL_CHAN_LSB     2
`define CTL_CHAN_MSB     5
`define REF_PCFG_LSB     0
`define REF_PCFG_MSB     3
`define REF_POS_BIT      4
`define REF_NEG_BIT      5
`define CLK_FIELD_MSB    7
`define CLK_FIELD_MASK   8'hbf
`define IRQ_DONE_BIT     0

// ****************************************
// Reset values and codes
// ****************************************
`define PCFG_ALL_ANALOG  4'h0
`define PCFG_DEFAULT_DIG 4'h7
`define PCFG_FIRST_DIG   4'h3
`define PCFG_ALL_DIGITAL 4'hf
`define PCFG_TOP_CODE    15
`define NUM_ANALOG_PINS  13
`define CHAN_LAST_REAL   4'hc
`define CHAN_SMALL_GAP_LO 4'h5
`define CHAN_SMALL_GAP_HI 4'h7
`define AXI_RESP_OKAY    2'b00
`define AXI_RESP_SLVERR  2'b10

`endif

// *** include/adc_cfg_pkg.sv ***
// Types shared by the converter control block
package adc_cfg_pkg;

    typedef enum logic [1:0] {
        CONV_IDLE   = 2'b00,
        CONV_ACTIVE = 2'b01
    } conv_state_t;

    // Reference and pin assignment handed to the analog side
    typedef struct packed {
        logic        neg_reference_select;
        logic        pos_reference_select;
        logic [12:0] pin_is_analog;
    } analog_route_t;

    // Request to the converter core
    typedef struct packed {
        logic       start;
        logic [3:0] input_channel_select;
        logic       channel_exists;
    } conv_req_t;

endpackage

// *** verilog/adc_channel_port_config.sv ***
// Converter control and port configuration with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"

// Function
// - Four-bit channel selector in control register 0 bits 5..2, codes 0..12 real
// - Codes 13..15 select no input; conversion still runs, floating result
// - On the small package codes 5, 6, 7 select nonexistent channels
// - Bit 1 reads one while converting with module enabled, else zero
// - Bit 0 enables the module; resets to zero
// - Control register 1 bit 5 picks negative reference: input 2 or ground
// - Control register 1 bit 4 picks positive reference: input 3 or supply
// - Port field bits 3..0: codes from 3 turn inputs digital from input 12
// - Port field resets to 0000 with fuse one, 0111 with fuse zero
// - Bits 7 and 6 of both control registers read zero
// - Each conversion yields a ten-bit result
// - Multiplexer offers ten inputs on small package, thirteen on large
// - Five software registers: result high, result low, three controls; the map also holds interrupt status and mask
// - On completion load result, clear status bit, set done flag
// - Reset returns registers to defaults, disables module, aborts conversion; the result register keeps its value
module adc_channel_port_config
    import adc_cfg_pkg::*;
#(
    parameter int ADDR_W    = 8,
    parameter bit SMALL_PKG = 1'b0
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst_n,
    // Configuration fuse
    input  wire logic                analog_default_fuse,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Converter core
    output conv_req_t                conv_req,
    input  wire logic                conv_done,
    input  wire logic [9:0]          conv_result,
    // Analog routing
    output analog_route_t            analog_route,
    output logic [7:0]               clock_acq_config,
    // Interrupt
    output logic                     irq
);

    // ****************************************
    // Register storage
    // ****************************************
    // Software-visible fields, one flip-flop group per register
    logic [3:0]  chan_sel_ff;
    logic        enable_ff;
    logic        neg_ref_ff;
    logic        pos_ref_ff;
    logic [3:0]  pcfg_ff;
    logic [7:0]  clk_acq_ff;
    logic [9:0]  result_ff;
    logic        done_flag_ff;
    logic        done_mask_ff;
    conv_state_t state_ff;
    conv_state_t nxt_state;
    logic        fuse_loaded_ff;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic [ADDR_W-1:0] aw_addr_ff;
    logic              aw_held_ff;
    logic [31:0]       w_data_ff;
    logic              w_strb0_ff;
    logic              w_held_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [1:0]        rresp_ff;
    logic [31:0]       rdata_ff;
    logic              wr_fire;
    logic [7:0]        wr_byte;
    logic [7:0]        wr_off;
    logic [7:0]        rd_off;
    logic              wr_hit;

    // Only one write and one read are held at a time; a second address waits until
    // the response has drained, which keeps the decode to a single held offset
    // Accept each channel once; hold until the response drains
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;

    // Write completes once both halves are held and the last response has drained
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_off  = 8'(aw_addr_ff);
    assign rd_off  = 8'(s_axi_araddr);
    // Only the low byte lane carries register data
    assign wr_byte = w_strb0_ff ? w_data_ff[7:0] : 8'h00;

    // Decode which offsets exist; anything else answers with an error
    always_comb begin
        unique case (wr_off)
            `OFF_CONTROL_CHANNEL_RUN, `OFF_REFERENCE_PORT_CONFIG, `OFF_CLOCK_ACQ_CONFIG,
            `OFF_RESULT_HIGH_BYTE, `OFF_RESULT_LOW_BYTE, `OFF_IRQ_STATUS, `OFF_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write address and data capture, in either order
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= 32'h0;
            w_strb0_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff  <= 1'b1;
                w_data_ff  <= s_axi_wdata;
                w_strb0_ff <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `AXI_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // One strobe per writable register, only when the low byte lane is enabled
    logic wr_ctl;
    logic wr_ref;
    logic wr_clk;
    logic wr_sts;
    logic wr_msk;
    assign wr_ctl = wr_fire && w_strb0_ff && (wr_off == `OFF_CONTROL_CHANNEL_RUN);
    assign wr_ref = wr_fire && w_strb0_ff && (wr_off == `OFF_REFERENCE_PORT_CONFIG);
    assign wr_clk = wr_fire && w_strb0_ff && (wr_off == `OFF_CLOCK_ACQ_CONFIG);
    assign wr_sts = wr_fire && w_strb0_ff && (wr_off == `OFF_IRQ_STATUS);
    assign wr_msk = wr_fire && w_strb0_ff && (wr_off == `OFF_IRQ_MASK);

    // ****************************************
    // Control register 0
    // ****************************************
    // Selector and enable; the run bit is not stored, the state machine stands for it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chan_sel_ff <= 4'h0;
            enable_ff   <= 1'b0;
        end else if (wr_ctl) begin
            chan_sel_ff <= wr_byte[`CTL_CHAN_MSB:`CTL_CHAN_LSB];
            enable_ff   <= wr_byte[`CTL_ENABLE_BIT];
        end
    end

    // ****************************************
    // Conversion sequencing
    // ****************************************
    // Start is a level for the whole conversion; the core must drop its done pulse
    // once start falls, or a stale pulse could end the next conversion early
    logic start_req;
    // Start only with the module enabled in the same write; else only selector and enable are stored
    assign start_req = wr_ctl && wr_byte[`CTL_RUN_BIT] && wr_byte[`CTL_ENABLE_BIT];

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            CONV_IDLE:   if (start_req) nxt_state = CONV_ACTIVE;
            CONV_ACTIVE: begin
                // Disabling aborts so a stale core cannot complete later
                if (wr_ctl && !wr_byte[`CTL_ENABLE_BIT]) nxt_state = CONV_IDLE;
                else if (conv_done) nxt_state = CONV_IDLE;
            end
            default:     nxt_state = CONV_IDLE;
        endcase
    end

    // State register; reset aborts any conversion in progress
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= CONV_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Completion counts only while running, so a late pulse after an abort is ignored
    logic done_event;
    assign done_event = (state_ff == CONV_ACTIVE) && conv_done && enable_ff;

    // Result holds across reset, as a real result pair would
    always_ff @(posedge clock) begin
        if (done_event) begin
            result_ff <= conv_result;
        end
    end

    // ****************************************
    // Control register 1 and fuse default
    // ****************************************
    // References and port field; the fuse decides the field's value after reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            neg_ref_ff     <= 1'b0;
            pos_ref_ff     <= 1'b0;
            pcfg_ff        <= `PCFG_ALL_ANALOG;
            fuse_loaded_ff <= 1'b0;
        end else if (!fuse_loaded_ff) begin
            // Fuse sampled on the first edge after release, not under reset
            fuse_loaded_ff <= 1'b1;
            pcfg_ff <= analog_default_fuse ? `PCFG_ALL_ANALOG : `PCFG_DEFAULT_DIG;
        end else if (wr_ref) begin
            neg_ref_ff <= wr_byte[`REF_NEG_BIT];
            pos_ref_ff <= wr_byte[`REF_POS_BIT];
            pcfg_ff    <= wr_byte[`REF_PCFG_MSB:`REF_PCFG_LSB];
        end
    end

    // Clock and acquisition byte, bit 6 unimplemented
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clk_acq_ff <= 8'h00;
        end else if (wr_clk) begin
            clk_acq_ff <= wr_byte & `CLK_FIELD_MASK;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    // Sticky completion flag with write-one-to-clear, and its mask
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_flag_ff <= 1'b0;
            done_mask_ff <= 1'b0;
        end else begin
            // Completion wins over a simultaneous write-one-to-clear
            if (done_event) done_flag_ff <= 1'b1;
            else if (wr_sts && wr_byte[`IRQ_DONE_BIT]) done_flag_ff <= 1'b0;
            if (wr_msk) done_mask_ff <= wr_byte[`IRQ_DONE_BIT];
        end
    end
    // Level interrupt while the unmasked flag is set
    assign irq = done_flag_ff && done_mask_ff;

    // ****************************************
    // Pin assignment and outputs
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_ANALOG_PINS; gi++) begin : g_pin
            // Input gi turns digital once the code reaches 15 - gi; codes below 3 keep all analog
            localparam logic [4:0] LIMIT = 5'(`PCFG_TOP_CODE - gi);
            assign analog_route.pin_is_analog[gi] =
                (pcfg_ff < `PCFG_FIRST_DIG) ||
                (({1'b0, pcfg_ff} < LIMIT) && (pcfg_ff != `PCFG_ALL_DIGITAL));
        end
    endgenerate
    // References pass straight through to the analog side
    assign analog_route.neg_reference_select = neg_ref_ff;
    assign analog_route.pos_reference_select = pos_ref_ff;
    assign clock_acq_config = clk_acq_ff;

    logic chan_real;
    // Codes above 12, and 5..7 on the small package, route nowhere but still convert
    assign chan_real = (chan_sel_ff <= `CHAN_LAST_REAL) &&
        !(SMALL_PKG && chan_sel_ff >= `CHAN_SMALL_GAP_LO && chan_sel_ff <= `CHAN_SMALL_GAP_HI);
    // Request to the core; start stands for the whole conversion
    assign conv_req.start                = (state_ff == CONV_ACTIVE);
    assign conv_req.input_channel_select = chan_sel_ff;
    assign conv_req.channel_exists       = chan_real;

    // ****************************************
    // Read path
    // ****************************************
    // Read mux; unimplemented bits and unmapped offsets read zero
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (rd_off)
            `OFF_CONTROL_CHANNEL_RUN:   rd_byte = {2'b00, chan_sel_ff,
                                                   (state_ff == CONV_ACTIVE) && enable_ff, enable_ff};
            `OFF_REFERENCE_PORT_CONFIG: rd_byte = {2'b00, neg_ref_ff, pos_ref_ff, pcfg_ff};
            `OFF_CLOCK_ACQ_CONFIG:      rd_byte = clk_acq_ff;
            `OFF_RESULT_HIGH_BYTE:      rd_byte = {6'h00, result_ff[9:8]};
            `OFF_RESULT_LOW_BYTE:       rd_byte = result_ff[7:0];
            `OFF_IRQ_STATUS:            rd_byte = {7'h00, done_flag_ff};
            `OFF_IRQ_MASK:              rd_byte = {7'h00, done_mask_ff};
            default: begin
                rd_byte = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // Data is captured when the address is taken, so it stays put while rvalid waits
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= `AXI_RESP_OKAY;
            rdata_ff  <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            rdata_ff  <= {24'h0, rd_byte};
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule // adc_channel_port_config

// *** bench/adc_cfg_assertions.sv ***
// Port assertions for the converter control block
`timescale 1ns/1ps
module adc_cfg_checker
    import adc_cfg_pkg::*;
#(
    parameter bit SMALL_PKG = 1'b0
) (
    // Clock, reset and fuse
    input wire logic          clock,
    input wire logic          rst_n,
    input wire logic          analog_default_fuse,
    // Register bus
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic          s_axi_rvalid,
    input wire logic [31:0]   s_axi_rdata,
    // Converter side
    input wire conv_req_t     conv_req,
    input wire logic          conv_done,
    input wire analog_route_t analog_route,
    input wire logic          irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ********
    // Sequences
    // ********
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence conv_finish;
        conv_done && conv_req.start;
    endsequence

    // ********
    // Assertions
    // ********
    a_write_gets_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_gets_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response missing");
    a_upper_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above the low byte not zero");
    a_done_ends_run: assert property (conv_finish |=> !conv_req.start)
        else $error("conversion still running after done");
    a_start_from_write: assert property ($rose(conv_req.start) |-> s_axi_bvalid)
        else $error("conversion started without a register write");
    a_no_input_code: assert property (conv_req.input_channel_select > 4'hc |-> !conv_req.channel_exists)
        else $error("unused selector code marked as existing");
    a_real_input_code: assert property (conv_req.input_channel_select <= 4'hc &&
        !(SMALL_PKG && conv_req.input_channel_select inside {[4'h5:4'h7]}) |-> conv_req.channel_exists)
        else $error("real selector code marked as missing");
    a_fuse_default: assert property ($rose(rst_n) |-> ##2
        analog_route.pin_is_analog == (analog_default_fuse ? 13'h1fff : 13'h00ff))
        else $error("port field default does not follow the fuse");
    a_reset_quiet: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !conv_req.start)
        else $error("outputs active right after reset");
endmodule // adc_cfg_checker

bind adc_channel_port_config adc_cfg_checker #(.SMALL_PKG(SMALL_PKG)) adc_cfg_checker_inst (
    .clock, .rst_n, .analog_default_fuse, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .conv_req, .conv_done,
    .analog_route, .irq
);

// *** bench/adc_core_model.sv ***
// Behavioural model of the converter core behind the multiplexer
`timescale 1ns/1ps
module adc_core_model
    import adc_cfg_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // Request and answer
    input wire conv_req_t  conv_req,
    input wire logic [7:0] lat,
    input wire logic [9:0] value,
    output logic           conv_done,
    output logic [9:0]     conv_result
);
    logic [7:0] wait_ff;

    // Any selector code converts, a missing input just reads as floating
    always_ff @(posedge clock) begin
        if (!rst_n || !conv_req.start || conv_done) begin
            wait_ff   <= 8'h00;
            conv_done <= 1'b0;
        end else begin
            wait_ff   <= wait_ff + 8'h01;
            conv_done <= (wait_ff == lat);
        end
    end

    // Inverse value outside the done cycle so a late sample cannot pass
    assign conv_result = conv_done ? value : ~value;
endmodule // adc_core_model

// *** bench/adc_channel_port_config_tb_top.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_channel_port_config_tb_top
    import adc_cfg_pkg::*;
;
    logic          clock, rst_n, analog_default_fuse, irq;
    logic [7:0]    s_axi_awaddr, s_axi_araddr, clock_acq_config, lat;
    logic [31:0]   s_axi_wdata, s_axi_rdata;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, conv_done;
    logic [9:0]    conv_result, value;
    conv_req_t     conv_req, small_req;
    analog_route_t analog_route;
    logic [33:0]   rq[$];
    logic [1:0]    wq[$];
    int            bad_count = 0, num_checks = 0, cycles = 0;

    adc_channel_port_config #(.ADDR_W(8), .SMALL_PKG(1'b0)) adc_channel_port_config_inst (
        .clock, .rst_n, .analog_default_fuse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_req,
        .conv_done, .conv_result, .analog_route, .clock_acq_config, .irq
    );
    adc_core_model adc_core_model_inst (.clock, .rst_n, .conv_req, .lat, .value, .conv_done, .conv_result);
    // Small-package copy on the same bus; only its channel decode is compared
    if (1) begin : g_small
        adc_channel_port_config #(.ADDR_W(8), .SMALL_PKG(1'b1)) adc_channel_port_config_inst (
            .clock, .rst_n, .analog_default_fuse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
            .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
            .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
            .s_axi_rready, .conv_req(small_req), .conv_done, .conv_result, .analog_route(), .clock_acq_config(),
            .irq()
        );
    end

    // ********
    // Checking and ending
    // ********
    task automatic chk(string what, logic [33:0] exp, logic [33:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ********
    // Bus master
    // ********
    task automatic reg_wr(logic [7:0] a, logic [7:0] d, logic [1:0] resp = `AXI_RESP_OKAY);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'($urandom()), d};
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        wq.push_back(resp);
        // Each channel is released on its own handshake
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge clock); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic reg_rd(logic [7:0] a, logic [31:0] exp, logic [1:0] resp = `AXI_RESP_OKAY);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        rq.push_back({resp, exp});
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // Clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Responses are matched against the oldest note; a hang ends the run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(wq.pop_front()), 34'(s_axi_bresp));
        if (s_axi_rvalid && s_axi_rready) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ********
    // Main sequence
    // ********
    initial begin
        logic [1:0]  r;
        logic [12:0] amask;
        {rst_n, analog_default_fuse, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        lat = 8'h0a;
        value = 10'h000;
        void'($urandom(20468));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        // Reset values, unmapped place, clock byte
        reg_rd(`OFF_CONTROL_CHANNEL_RUN, 32'h0);
        reg_rd(`OFF_REFERENCE_PORT_CONFIG, 32'h07);
        reg_rd(8'h1c, 32'h0, `AXI_RESP_SLVERR);
        reg_wr(8'h1c, 8'hff, `AXI_RESP_SLVERR);
        reg_wr(`OFF_CLOCK_ACQ_CONFIG, 8'hff);
        reg_rd(`OFF_CLOCK_ACQ_CONFIG, 32'hbf);
        chk("clock_acq_config", 34'hbf, 34'(clock_acq_config));
        // A write without the low byte lane leaves the register alone
        s_axi_wstrb <= 4'he;
        reg_wr(`OFF_CLOCK_ACQ_CONFIG, 8'h00);
        s_axi_wstrb <= 4'hf;
        reg_rd(`OFF_CLOCK_ACQ_CONFIG, 32'hbf);
        // Every port code with random references
        for (int c = 0; c < 16; c++) begin
            r = 2'($urandom());
            reg_wr(`OFF_REFERENCE_PORT_CONFIG, {2'b11, r, 4'(c)});
            reg_rd(`OFF_REFERENCE_PORT_CONFIG, {26'h0, r, 4'(c)});
            amask = (c < 3) ? 13'h1fff : 13'((14'h1 << (15 - c)) - 14'h1);
            chk("analog_route", 34'({r, amask}), 34'(analog_route));
        end
        // Every selector code converted, interrupt masked on even codes
        for (int ch = 0; ch < 16; ch++) begin
            value <= 10'($urandom());
            lat <= 8'(10 + $urandom_range(7));
            reg_wr(`OFF_IRQ_MASK, {7'h0, 1'(ch)});
            reg_wr(`OFF_CONTROL_CHANNEL_RUN, {2'b11, 4'(ch), 2'b11});
            chk("channel", 34'({4'(ch), 1'(ch < 13)}),
                34'({conv_req.input_channel_select, conv_req.channel_exists}));
            chk("small channel", 34'(ch < 13 && !(ch inside {[5:7]})), 34'(small_req.channel_exists));
            reg_rd(`OFF_CONTROL_CHANNEL_RUN, {26'h0, 4'(ch), 2'b11});
            do @(posedge clock); while (conv_req.start);
            reg_rd(`OFF_CONTROL_CHANNEL_RUN, {26'h0, 4'(ch), 2'b01});
            reg_rd(`OFF_RESULT_HIGH_BYTE, {30'h0, value[9:8]});
            reg_rd(`OFF_RESULT_LOW_BYTE, {24'h0, value[7:0]});
            reg_rd(`OFF_IRQ_STATUS, 32'h1);
            chk("irq", 34'(ch % 2), 34'(irq));
            reg_wr(`OFF_IRQ_STATUS, 8'h01);
            reg_rd(`OFF_IRQ_STATUS, 32'h0);
            chk("irq", 34'h0, 34'(irq));
        end
        // Run request while disabled starts nothing
        reg_wr(`OFF_CONTROL_CHANNEL_RUN, 8'h0a);
        reg_rd(`OFF_CONTROL_CHANNEL_RUN, 32'h08);
        chk("start", 34'(conv_req.start), 34'h0);
        // Reset in mid-conversion with the fuse now set
        lat <= 8'hff;
        reg_wr(`OFF_REFERENCE_PORT_CONFIG, 8'h3f);
        reg_wr(`OFF_CONTROL_CHANNEL_RUN, 8'h07);
        analog_default_fuse <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        chk("start", 34'(conv_req.start), 34'h0);
        repeat (2) @(posedge clock);
        reg_rd(`OFF_CONTROL_CHANNEL_RUN, 32'h0);
        reg_rd(`OFF_REFERENCE_PORT_CONFIG, 32'h0);
        complete_run();
    end
endmodule // adc_channel_port_config_tb_top
